// ==== hw/mpd_defines.vh ====
// Purpose: Shared constants for the memory page and port address decoder.
// Assumes: Included by every design file of the block by its bare name.
// Notes: Offsets are address bit positions; codes are port low digits.
`ifndef MPD_DEFINES_VH
`define MPD_DEFINES_VH

// Address fields of the system RAM and page decoder.
`define MPD_ROW_LSB 0
`define MPD_ROW_MSB 4
`define MPD_COL_LSB 5
`define MPD_COL_MSB 9
`define MPD_PAGE_LSB 10
`define MPD_PAGE_MSB 15

// High nibble that enables the page decoder, and the page codes in bits 11:10.
`define MPD_PAGE_NIBBLE 4'hC
`define MPD_PAGE_C0 2'h0
`define MPD_PAGE_C4 2'h1
`define MPD_PAGE_C8 2'h2
`define MPD_PAGE_CC 2'h3

// Port decode: bits 15:11 all ones, bits 10:8 select the port.
`define MPD_PORT_PREFIX 5'h1F
`define MPD_PORT_SEL_LSB 8
`define MPD_PORT_SEL_MSB 10

// Port indices within each decoder (low three bits of the port number).
`define MPD_PORT_F8 3'h0
`define MPD_PORT_F9 3'h1
`define MPD_PORT_FA 3'h2
`define MPD_PORT_FB 3'h3
`define MPD_PORT_FC 3'h4
`define MPD_PORT_FD 3'h5
`define MPD_PORT_FE 3'h6
`define MPD_PORT_FF 3'h7

// Data bit that feeds the request-to-send latch.
`define MPD_RTS_BIT 4

// Input multiplexer select codes {B, A}.
`define MPD_MUX_INTERNAL 2'h0
`define MPD_MUX_PARALLEL 2'h1
`define MPD_MUX_KEYBOARD 2'h2
`define MPD_MUX_BIDIR 2'h3

// Boot overlay length in instruction fetches after reset.
`define MPD_BOOT_FETCHES 3'h4

// Reset values.
`define MPD_RESET_STROBES 8'hFF
`define MPD_RESET_RTS 1'b0

`endif

// ==== hw/mpd_page_decoder.v ====
// Purpose: Combinational memory page decode for ROM, system RAM and display RAM.
// Assumes: Address and status are stable for the whole decode.
// Notes: Outputs are active low, one per page.
`include "mpd_defines.vh"

module mpd_page_decoder (
  // Address and status
  input wire [15:0] cpuAddress,
  input wire statusInput,
  input wire statusOutput,
  input wire intAckBlock,
  input wire bootOverlay_n,
  // Page selects, active low
  output reg [3:0] pageSel_n
);

  reg decodeEnable;
  reg [1:0] pageCode;
  reg cPage;
  reg bootPage;

  always @* begin
    decodeEnable = !statusInput && !statusOutput && !intAckBlock;
    cPage = (cpuAddress[15:12] == `MPD_PAGE_NIBBLE) && bootOverlay_n;
    bootPage = !bootOverlay_n && (cpuAddress[`MPD_PAGE_MSB:`MPD_PAGE_LSB] == 6'h00);
    pageCode = cpuAddress[11:10];
    pageSel_n = 4'hF;
    if (decodeEnable && bootPage) begin
      pageSel_n[`MPD_PAGE_C0] = 1'b0;
    end else if (decodeEnable && cPage) begin
      pageSel_n[pageCode] = 1'b0;
    end
  end

endmodule

// ==== hw/mpd_port_decoder.v ====
// Purpose: Combinational input and output port strobe decode for ports F8 to FF.
// Assumes: Address and status are stable while the strobes are qualified.
// Notes: Strobes are active low, indexed by the low three bits of the port.
`include "mpd_defines.vh"

module mpd_port_decoder (
  // Address and status
  input wire [15:0] cpuAddress,
  input wire statusInput,
  input wire statusOutput,
  input wire dataBusIn,
  input wire write_n,
  input wire intAckBlock,
  // Strobes, active low
  output reg [7:0] inStrobe_n,
  output reg [7:0] outStrobe_n,
  output reg internalSel
);

  reg portHit;
  reg [2:0] portIndex;

  // Returns an active low one-hot of the index when enabled.
  function [7:0] decodeLow;
    input enable;
    input [2:0] index;
    begin
      decodeLow = 8'hFF;
      if (enable) begin
        decodeLow[index] = 1'b0;
      end
    end
  endfunction

  always @* begin
    portHit = (cpuAddress[15:11] == `MPD_PORT_PREFIX) && !intAckBlock;
    portIndex = cpuAddress[`MPD_PORT_SEL_MSB:`MPD_PORT_SEL_LSB];
    inStrobe_n = decodeLow(portHit && statusInput && dataBusIn, portIndex);
    outStrobe_n = decodeLow(portHit && statusOutput && !write_n, portIndex);
    // internal bus for F8 to FB
    internalSel = (inStrobe_n[3:0] != 4'hF);
  end

endmodule

// ==== hw/mpd_memory_port_decoder.v ====
// Purpose: Memory page selects, port strobes and one-wait-state ready for the CPU board.
// Assumes: All inputs but arst_n are synchronous to clock; phase2 is the sampled phase-2 clock.
// Notes: Every output is registered, so decodes appear one clock after their cause.
// What this block does
// - System RAM selected only at C800-CBFF
// - RAM rows bits 0-4, columns 5-9
// - RAM write only while memory-write high
// - Two ROM page selects, C0 and C4
// - Page decode needs bits 15-12 1100
// - Memory select when any page decoded
// - Boot overlay maps page zero to C0
// - No page decode during I/O status
// - Ready low mid-sync to next phase-2 rise
// - Ports respond only for F8 to FF
// - Bits 8-10 choose one of eight
// - Input strobe needs input status and strobe
// - Output strobe needs output status and write
// - Internal bus select on F8-FB reads
// - Jumpered interrupt acknowledge disables all decoders
// - Output strobe map FE down to F8
// - Input strobe map FF down to F8
// - Port FE read returns display status bits
// - Port FD read resets parallel handshake
// - Request-to-send latch takes data bit 4
// - Boot overlay low for first four fetches
// - ROM/RAM on internal bus, display bidirectional
`include "mpd_defines.vh"

module mpd_memory_port_decoder (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // CPU address and status
  input wire [15:0] cpuAddress,
  input wire statusInput,
  input wire statusOutput,
  input wire statusMemWrite,
  input wire statusIntAck,
  input wire dataBusIn,
  input wire write_n,
  input wire sync,
  input wire phase2,
  // Board options and data
  input wire intAckJumper,
  input wire [7:0] bidirData,
  input wire scrollTimerStatus,
  input wire screenPosStatus,
  // Memory selects
  output reg romC0Sel_n,
  output reg romC4Sel_n,
  output reg systemRamSel_n,
  output reg displayRamSel_n,
  output reg memSelect,
  output reg ramWriteEnable_n,
  output reg [4:0] ramRow,
  output reg [4:0] ramColumn,
  // Wait state
  output reg ready,
  // Boot overlay
  output reg bootOverlay_n,
  // Output strobes
  output reg scroll_load_strobe_n,
  output reg parallel_out_strobe_n,
  output reg cassette_tx_strobe_n,
  output reg control_bits_strobe_n,
  output reg serial_tx_load_strobe_n,
  output reg rts_latch_strobe_n,
  // Input strobes
  output reg sense_switch_strobe_n,
  output reg display_status_strobe_n,
  output reg parallel_in_strobe_n,
  output reg keyboard_read_strobe_n,
  output reg cassette_rx_strobe_n,
  output reg combined_status_strobe_n,
  output reg serial_rx_strobe_n,
  output reg serial_status_strobe_n,
  // Data path steering
  output reg internalBusSel,
  output reg [1:0] inputMuxSelect,
  output reg parallelHandshakeReset,
  output reg rtsLatch,
  output reg [7:0] readData,
  output reg readDataEnable
);

  reg [1:0] resetSync;
  wire rst_n;
  wire intAckBlock;
  wire [3:0] pageSel_n;
  wire [7:0] inDecode_n;
  wire [7:0] outDecode_n;
  wire internalDecode;
  reg anyPage;
  reg waitActive;
  reg next_waitActive;
  reg phase2Prev;
  reg phase2Rise;
  reg cycleQualifies;
  reg dataBusInPrev;
  reg [2:0] fetchCount;
  reg [1:0] next_muxSelect;
  reg [2:0] next_fetchCount;
  reg next_bootOverlay_n;
  reg next_rtsLatch;

  // True when the active low strobe of the given port index is asserted.
  function portActive;
    input [7:0] strobes_n;
    input [2:0] index;
    begin
      portActive = !strobes_n[index];
    end
  endfunction

  // Reset is applied at once and released through two flip-flops.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resetSync <= 2'h0;
    end else begin
      resetSync <= {resetSync[0], 1'b1};
    end
  end

  assign rst_n = resetSync[1];

  assign intAckBlock = intAckJumper && statusIntAck;

  mpd_page_decoder pageDecoder (
    .cpuAddress(cpuAddress),
    .statusInput(statusInput),
    .statusOutput(statusOutput),
    .intAckBlock(intAckBlock),
    .bootOverlay_n(bootOverlay_n),
    .pageSel_n(pageSel_n)
  );

  mpd_port_decoder portDecoder (
    .cpuAddress(cpuAddress),
    .statusInput(statusInput),
    .statusOutput(statusOutput),
    .dataBusIn(dataBusIn),
    .write_n(write_n),
    .intAckBlock(intAckBlock),
    .inStrobe_n(inDecode_n),
    .outStrobe_n(outDecode_n),
    .internalSel(internalDecode)
  );

  always @* begin
    anyPage = (pageSel_n != 4'hF);
    phase2Rise = phase2 && !phase2Prev;
    cycleQualifies = anyPage || statusInput || statusOutput;
    next_waitActive = waitActive;
    // A new sync wins over a pending release, so back-to-back cycles keep their wait.
    // The release waits for a phase-2 rise with sync low, where the CPU samples ready.
    if (sync && phase2 && cycleQualifies) begin
      next_waitActive = 1'b1;
    end else if (waitActive && !sync && phase2Rise) begin
      next_waitActive = 1'b0;
    end
    // data bus steering
    // Port reads outrank the page steering, since a port read never decodes a page.
    if (portActive(inDecode_n, `MPD_PORT_FC)) begin
      next_muxSelect = `MPD_MUX_KEYBOARD;
    end else if (portActive(inDecode_n, `MPD_PORT_FD)) begin
      next_muxSelect = `MPD_MUX_PARALLEL;
    end else if (internalDecode) begin
      next_muxSelect = `MPD_MUX_INTERNAL;
    end else if (anyPage && pageSel_n[`MPD_PAGE_CC]) begin
      next_muxSelect = `MPD_MUX_INTERNAL;
    end else begin
      next_muxSelect = `MPD_MUX_BIDIR;
    end
    next_fetchCount = fetchCount;
    if (dataBusInPrev && !dataBusIn && fetchCount != `MPD_BOOT_FETCHES) begin
      next_fetchCount = fetchCount + 3'h1;
    end
    // The overlay is released one clock after the fourth count and never returns.
    next_bootOverlay_n = bootOverlay_n;
    if (fetchCount == `MPD_BOOT_FETCHES) begin
      next_bootOverlay_n = 1'b1;
    end
    next_rtsLatch = rtsLatch;
    if (portActive(outDecode_n, `MPD_PORT_F8)) begin
      next_rtsLatch = bidirData[`MPD_RTS_BIT];
    end
  end

  // Ready is loaded from next_waitActive, so it turns on the same clock as waitActive; every top output is a flop.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitActive <= 1'b0;
      ready <= 1'b1;
      phase2Prev <= 1'b0;
    end else begin
      waitActive <= next_waitActive;
      ready <= !next_waitActive;
      phase2Prev <= phase2;
    end
  end

  // Boot overlay counts data-bus-in pulses from reset and then stays released.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataBusInPrev <= 1'b0;
      fetchCount <= 3'h0;
      bootOverlay_n <= 1'b0;
    end else begin
      dataBusInPrev <= dataBusIn;
      fetchCount <= next_fetchCount;
      bootOverlay_n <= next_bootOverlay_n;
    end
  end

  // Memory selects and RAM addressing.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      romC0Sel_n <= 1'b1;
      romC4Sel_n <= 1'b1;
      systemRamSel_n <= 1'b1;
      displayRamSel_n <= 1'b1;
      memSelect <= 1'b0;
      ramWriteEnable_n <= 1'b1;
      ramRow <= 5'h00;
      ramColumn <= 5'h00;
    end else begin
      romC0Sel_n <= pageSel_n[`MPD_PAGE_C0];
      romC4Sel_n <= pageSel_n[`MPD_PAGE_C4];
      systemRamSel_n <= pageSel_n[`MPD_PAGE_C8];
      displayRamSel_n <= pageSel_n[`MPD_PAGE_CC];
      memSelect <= anyPage;
      ramWriteEnable_n <= !(statusMemWrite && !pageSel_n[`MPD_PAGE_C8]);
      ramRow <= cpuAddress[`MPD_ROW_MSB:`MPD_ROW_LSB];
      ramColumn <= cpuAddress[`MPD_COL_MSB:`MPD_COL_LSB];
    end
  end

  // Output port strobes.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scroll_load_strobe_n <= 1'b1;
      parallel_out_strobe_n <= 1'b1;
      cassette_tx_strobe_n <= 1'b1;
      control_bits_strobe_n <= 1'b1;
      serial_tx_load_strobe_n <= 1'b1;
      rts_latch_strobe_n <= 1'b1;
      rtsLatch <= `MPD_RESET_RTS;
    end else begin
      scroll_load_strobe_n <= outDecode_n[`MPD_PORT_FE];
      parallel_out_strobe_n <= outDecode_n[`MPD_PORT_FD];
      cassette_tx_strobe_n <= outDecode_n[`MPD_PORT_FB];
      control_bits_strobe_n <= outDecode_n[`MPD_PORT_FA];
      serial_tx_load_strobe_n <= outDecode_n[`MPD_PORT_F9];
      rts_latch_strobe_n <= outDecode_n[`MPD_PORT_F8];
      rtsLatch <= next_rtsLatch;
    end
  end

  // Input port strobes and read data steering.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sense_switch_strobe_n <= 1'b1;
      display_status_strobe_n <= 1'b1;
      parallel_in_strobe_n <= 1'b1;
      keyboard_read_strobe_n <= 1'b1;
      cassette_rx_strobe_n <= 1'b1;
      combined_status_strobe_n <= 1'b1;
      serial_rx_strobe_n <= 1'b1;
      serial_status_strobe_n <= 1'b1;
      internalBusSel <= 1'b0;
      inputMuxSelect <= `MPD_MUX_BIDIR;
      parallelHandshakeReset <= 1'b0;
      readData <= 8'h00;
      readDataEnable <= 1'b0;
    end else begin
      sense_switch_strobe_n <= inDecode_n[`MPD_PORT_FF];
      display_status_strobe_n <= inDecode_n[`MPD_PORT_FE];
      parallel_in_strobe_n <= inDecode_n[`MPD_PORT_FD];
      keyboard_read_strobe_n <= inDecode_n[`MPD_PORT_FC];
      cassette_rx_strobe_n <= inDecode_n[`MPD_PORT_FB];
      combined_status_strobe_n <= inDecode_n[`MPD_PORT_FA];
      serial_rx_strobe_n <= inDecode_n[`MPD_PORT_F9];
      serial_status_strobe_n <= inDecode_n[`MPD_PORT_F8];
      internalBusSel <= internalDecode;
      inputMuxSelect <= next_muxSelect;
      parallelHandshakeReset <= portActive(inDecode_n, `MPD_PORT_FD);
      // display status on bits 1:0
      // The status pair is driven on every clock; readDataEnable marks when it is valid.
      readDataEnable <= portActive(inDecode_n, `MPD_PORT_FE);
      readData <= {6'h00, screenPosStatus, scrollTimerStatus};
    end
  end

endmodule

// ==== verif/mpd_memory_port_decoder_properties.sv ====
// Purpose: Concurrent checks on page selects, port strobes and the ready wait state.
// Assumes: Every output follows its cause by one clock once reset has settled.
// Notes: Checks begin on the fourth clock after reset release.
module mpd_checker (
  // Clock and reset
  input logic clock,
  input logic arst_n,
  // Address and status
  input logic [15:0] cpuAddress,
  input logic statusInput,
  input logic statusOutput,
  input logic statusMemWrite,
  input logic statusIntAck,
  input logic dataBusIn,
  input logic write_n,
  input logic sync,
  input logic phase2,
  input logic intAckJumper,
  input logic [7:0] bidirData,
  // Memory side
  input logic romC0Sel_n,
  input logic romC4Sel_n,
  input logic systemRamSel_n,
  input logic displayRamSel_n,
  input logic memSelect,
  input logic ramWriteEnable_n,
  input logic [4:0] ramRow,
  input logic [4:0] ramColumn,
  input logic ready,
  input logic bootOverlay_n,
  // Port side
  input logic scroll_load_strobe_n,
  input logic parallel_out_strobe_n,
  input logic cassette_tx_strobe_n,
  input logic control_bits_strobe_n,
  input logic serial_tx_load_strobe_n,
  input logic rts_latch_strobe_n,
  input logic sense_switch_strobe_n,
  input logic display_status_strobe_n,
  input logic parallel_in_strobe_n,
  input logic keyboard_read_strobe_n,
  input logic cassette_rx_strobe_n,
  input logic combined_status_strobe_n,
  input logic serial_rx_strobe_n,
  input logic serial_status_strobe_n,
  input logic internalBusSel,
  input logic rtsLatch
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] age;
  logic ov1, ov2, on, st, pg, cpg, pq;
  logic [7:0] ie, oe;
  // The overlay history keeps page checks away from the overlay's own switch-over.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      age <= 2'h0;
      ov1 <= 1'b0;
      ov2 <= 1'b0;
    end else begin
      age <= (age == 2'h3) ? age : age + 2'h1;
      ov1 <= bootOverlay_n;
      ov2 <= ov1;
    end
  end
  assign on = age == 2'h3;
  assign st = on && ov1 == bootOverlay_n && ov2 == bootOverlay_n;
  assign pg = !statusInput && !statusOutput && !(intAckJumper && statusIntAck);
  assign cpg = pg && bootOverlay_n && cpuAddress[15:12] == 4'hC;
  assign pq = cpuAddress[15:11] == 5'h1F && !(intAckJumper && statusIntAck);
  assign ie = (pq && statusInput && dataBusIn) ? ~(8'h01 << cpuAddress[10:8]) : 8'hFF;
  assign oe = (pq && statusOutput && !write_n) ? ~(8'h01 << cpuAddress[10:8]) : 8'hFF;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  a_c0_select: assert property (st |-> romC0Sel_n ==
    !$past(pg && cpuAddress[15:10] == (bootOverlay_n ? 6'h30 : 6'h00)))
    else $error("C0 page select wrong");
  a_c8_select: assert property (st |-> systemRamSel_n ==
    !$past(cpg && cpuAddress[11:10] == 2'h2)) else $error("C8 page select wrong");
  a_cc_select: assert property (st |-> displayRamSel_n ==
    !$past(cpg && cpuAddress[11:10] == 2'h3)) else $error("CC page select wrong");
  a_c4_select: assert property (st |-> romC4Sel_n ==
    !$past(cpg && cpuAddress[11:10] == 2'h1)) else $error("C4 page select wrong");
  a_one_select: assert property (on |-> $onehot0({~romC0Sel_n, ~romC4Sel_n,
    ~systemRamSel_n, ~displayRamSel_n})) else $error("more than one page select");
  a_mem_select: assert property (on |-> memSelect ==
    !(romC0Sel_n && romC4Sel_n && systemRamSel_n && displayRamSel_n))
    else $error("memory select wrong");
  a_ram_write: assert property (on |-> ramWriteEnable_n ==
    (systemRamSel_n || !$past(statusMemWrite))) else $error("RAM write enable wrong");
  a_row_column: assert property (on |-> {ramColumn, ramRow} ==
    $past(cpuAddress[9:0])) else $error("RAM row or column wrong");
  a_in_strobes: assert property (on |-> $past(ie) ==
    {sense_switch_strobe_n, display_status_strobe_n, parallel_in_strobe_n,
    keyboard_read_strobe_n, cassette_rx_strobe_n, combined_status_strobe_n,
    serial_rx_strobe_n, serial_status_strobe_n}) else $error("input strobes wrong");
  a_out_strobes: assert property (on |-> {$past(oe[6:5]), $past(oe[3:0])} ==
    {scroll_load_strobe_n, parallel_out_strobe_n, cassette_tx_strobe_n,
    control_bits_strobe_n, serial_tx_load_strobe_n, rts_latch_strobe_n})
    else $error("output strobes wrong");
  a_internal_sel: assert property (on |-> internalBusSel ==
    $past(ie[3:0] != 4'hF)) else $error("internal bus select wrong");
  a_ready_wait: assert property (on && sync && phase2 &&
    (statusInput || statusOutput || cpg) |=> !ready) else $error("ready not pulled low");
  a_ready_release: assert property (on && !ready && !sync && phase2 &&
    !$past(phase2) |=> ready) else $error("ready not released");
  a_ready_hold: assert property (on && !ready && !phase2 |=> !ready)
    else $error("ready released early");
  a_rts_latch: assert property (on && !rts_latch_strobe_n |->
    rtsLatch == $past(bidirData[4])) else $error("request-to-send latch wrong");
endmodule

bind mpd_memory_port_decoder mpd_checker mpd_checker_i (.*);

// ==== verif/mpd_cpu_model.sv ====
// Purpose: Cycle-level CPU side: sync, phase-2 and ready sampling per machine cycle.
// Assumes: One machine cycle per go pulse; the bench holds address and status.
// Notes: Sync and phase-2 stand low between machine cycles.
module mpd_cpu_model (
  // Clock
  input logic clock,
  // Cycle request and ready
  input logic go,
  input logic ready,
  // Bus timing and wait count
  output logic sync,
  output logic phase2,
  output logic [3:0] waits
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] step = 3'h0;
  initial begin
    sync = 1'b0;
    phase2 = 1'b0;
    waits = 4'h0;
  end
  always @(posedge clock) begin
    if (go) begin
      sync <= 1'b1;
      phase2 <= 1'b1;
      waits <= 4'h0;
      step <= 3'h1;
    end else if (step != 3'h0) begin
      if (phase2 && !sync && !ready) begin
        waits <= waits + 4'h1;
      end
      sync <= 1'b0;
      phase2 <= !step[0];
      step <= step + 3'h1;
    end
  end
endmodule

// ==== verif/mpd_memory_port_decoder_tb.sv ====
// Purpose: Self-checking bench for the page, port and wait-state decoder.
// Assumes: Outputs answer one clock after the inputs that cause them.
// Notes: Status word is {input, output, memwrite, intack, databusin, write_n}.
module mpd_memory_port_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, arst_n = 1'b0, go = 1'b0;
  logic [15:0] cpuAddress = 16'h8000;
  logic statusInput = 1'b0, statusOutput = 1'b0, statusMemWrite = 1'b0, statusIntAck = 1'b0;
  logic dataBusIn = 1'b0, write_n = 1'b1, intAckJumper = 1'b0;
  logic [7:0] bidirData = 8'h00;
  logic scrollTimerStatus = 1'b0, screenPosStatus = 1'b1;
  logic sync, phase2, romC0Sel_n, romC4Sel_n, systemRamSel_n, displayRamSel_n, memSelect;
  logic ramWriteEnable_n, ready, bootOverlay_n, internalBusSel, parallelHandshakeReset;
  logic rtsLatch, readDataEnable, scroll_load_strobe_n, parallel_out_strobe_n;
  logic cassette_tx_strobe_n, control_bits_strobe_n, serial_tx_load_strobe_n;
  logic rts_latch_strobe_n, sense_switch_strobe_n, display_status_strobe_n;
  logic parallel_in_strobe_n, keyboard_read_strobe_n, cassette_rx_strobe_n;
  logic combined_status_strobe_n, serial_rx_strobe_n, serial_status_strobe_n;
  logic [1:0] inputMuxSelect;
  logic [3:0] waits;
  logic [4:0] ramRow, ramColumn;
  logic [7:0] readData, iv, ov;
  int n_mismatch = 0;
  int samples_checked = 0;
  assign iv = {sense_switch_strobe_n, display_status_strobe_n, parallel_in_strobe_n,
    keyboard_read_strobe_n, cassette_rx_strobe_n, combined_status_strobe_n,
    serial_rx_strobe_n, serial_status_strobe_n};
  assign ov = {1'b1, scroll_load_strobe_n, parallel_out_strobe_n, 1'b1, cassette_tx_strobe_n,
    control_bits_strobe_n, serial_tx_load_strobe_n, rts_latch_strobe_n};
  always #12.5 clock = ~clock;
  mpd_memory_port_decoder mpd_memory_port_decoder_i (.*);
  mpd_cpu_model mpd_cpu_model_i (.*);

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task put(input logic [15:0] a, input logic [5:0] s, input logic [7:0] d = 8'h00);
    @(posedge clock);
    cpuAddress <= a;
    {statusInput, statusOutput, statusMemWrite, statusIntAck, dataBusIn, write_n} <= s;
    bidirData <= d;
    @(posedge clock);
    @(posedge clock);
    #1;
  endtask
  task cyc(input logic [15:0] a, input logic [5:0] s, input logic [3:0] w);
    put(a, s);
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (10) @(posedge clock);
    #1;
    chk(waits, w);
  endtask

  task t_boot;
    put(16'h0000, 6'h01);
    chk(romC0Sel_n, 1'b0);
    put(16'hC000, 6'h01);
    chk({romC0Sel_n, memSelect}, 2'h2);
    for (int i = 0; i < 4; i++) begin
      chk(bootOverlay_n, 1'b0);
      put(16'h8000, 6'h03);
      put(16'h8000, 6'h01);
    end
    put(16'h0000, 6'h01);
    chk({bootOverlay_n, romC0Sel_n}, 2'h3);
    $display("test boot done");
  endtask
  task t_pages;
    for (int i = 0; i < 4; i++) begin
      put({4'hC, i[1:0], 10'h2A5}, 6'h01);
      chk({displayRamSel_n, systemRamSel_n, romC4Sel_n, romC0Sel_n}, 4'(~(4'h1 << i)));
      chk({memSelect, ramColumn, ramRow}, {1'b1, 10'h2A5});
      chk(inputMuxSelect, (i == 3) ? 2'h3 : 2'h0);
      put({4'hC, i[1:0], 10'h2A5}, 6'h08);
      chk({ramWriteEnable_n, memSelect}, {i != 2, 1'b1});
    end
    put(16'hD800, 6'h01);
    chk(memSelect, 1'b0);
    $display("test pages done");
  endtask
  task t_blocks;
    put(16'hC800, 6'h21);
    chk(systemRamSel_n, 1'b1);
    put(16'hC800, 6'h11);
    chk(systemRamSel_n, 1'b1);
    put(16'hC800, 6'h05);
    chk(systemRamSel_n, 1'b0);
    @(posedge clock);
    intAckJumper <= 1'b1;
    put(16'hC800, 6'h05);
    chk(systemRamSel_n, 1'b1);
    put(16'hF800, 6'h14);
    chk(ov, 8'hFF);
    put(16'hF800, 6'h27);
    chk(iv, 8'hFF);
    @(posedge clock);
    intAckJumper <= 1'b0;
    $display("test blocks done");
  endtask
  task t_in_ports;
    for (int p = 0; p < 8; p++) begin
      put({5'h1F, p[2:0], 8'h00}, 6'h23);
      chk(iv, 8'(~(8'h01 << p)));
      chk(internalBusSel, p < 4);
      chk({parallelHandshakeReset, readDataEnable}, {p == 5, p == 6});
      chk(inputMuxSelect, (p == 4) ? 2'h2 : (p == 5) ? 2'h1 : (p < 4) ? 2'h0 : 2'h3);
      if (p == 6) chk(readData, 8'h02);
    end
    @(posedge clock);
    {scrollTimerStatus, screenPosStatus} <= 2'h2;
    put(16'hFE00, 6'h23);
    chk(readData, 8'h01);
    put(16'hFAFF, 6'h23);
    chk(iv, 8'hFB);
    put(16'hFC00, 6'h21);
    chk(iv, 8'hFF);
    put(16'hF400, 6'h23);
    chk(iv, 8'hFF);
    $display("test input ports done");
  endtask
  task t_out_ports;
    for (int p = 0; p < 8; p++) begin
      put({5'h1F, p[2:0], 8'h00}, 6'h10, 8'h10);
      chk(ov, 8'(~(8'h01 << p)) | 8'h90);
    end
    chk(rtsLatch, 1'b1);
    put(16'hF800, 6'h10, 8'hEF);
    chk(rtsLatch, 1'b0);
    put(16'hF900, 6'h11);
    chk(ov, 8'hFF);
    $display("test output ports done");
  endtask
  task t_wait;
    cyc(16'hC800, 6'h01, 4'h1);
    cyc(16'hF800, 6'h23, 4'h1);
    cyc(16'hF800, 6'h10, 4'h1);
    cyc(16'h8000, 6'h01, 4'h0);
    $display("test wait state done");
  endtask

  task t_reset;
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk({bootOverlay_n, ready, memSelect}, 3'h2);
    @(posedge clock);
    put(16'h0000, 6'h01);
    chk({bootOverlay_n, romC0Sel_n}, 2'h0);
    $display("test reset done");
  endtask

  task tally_and_finish;
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_boot;
    t_pages;
    t_blocks;
    t_in_ports;
    t_out_ports;
    t_wait;
    t_reset;
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
